/* rtl/clsf_regs.vh */
// register offsets, field positions and reset values of the link status flag bank
`ifndef CLSF_REGS_VH
`define CLSF_REGS_VH

// word offsets (register index)
`define CLSF_ADDR_W        4
`define CLSF_OFS_PORT_FLAGS  4'h0
`define CLSF_OFS_LINK_FLAGS  4'h1
`define CLSF_OFS_ASSURE      4'h2
`define CLSF_OFS_ERR_CODE    4'h3
`define CLSF_OFS_END_CODE    4'h4
`define CLSF_OFS_IRQ_STATUS  4'h5
`define CLSF_OFS_IRQ_CLEAR   4'h6
`define CLSF_OFS_IRQ_ENABLE  4'h7

// bit positions inside the port/arc flag word
`define CLSF_BIT_MODE        2
`define CLSF_BIT_ERR         7
`define CLSF_BIT_RXDONE      8
`define CLSF_BIT_TXDONE      9
`define CLSF_BIT_NETAVAIL    10
`define CLSF_BIT_NETFAULT    11
`define CLSF_BIT_ARCCTL      14
`define CLSF_BIT_ARCCONF     15

// interrupt status bit positions
`define CLSF_IRQ_ERR         0
`define CLSF_IRQ_RXDONE      1
`define CLSF_IRQ_TXDONE      2
`define CLSF_IRQ_NETDONE     3
`define CLSF_IRQ_LINKERR     4
`define CLSF_IRQ_W           5

`define CLSF_NODES           16
`define CLSF_ZERO16          16'h0000
`define CLSF_ZERO5           5'h00
`define CLSF_ZERO6           6'h00
`define CLSF_ONE1            1'h1
`define CLSF_ZERO1           1'h0

`endif

/* rtl/clsf_status_flags.v */
// status flag bank for second serial port, network instructions, arc interpolation, link
// Function
// - error flag sets on a transmission error on the second port.
// - error flag clears when the serial transmit instruction requests sending.
// - in general-purpose mode rx done sets on terminator arrival.
// - in general-purpose mode tx done sets when transmission fully completes.
// - tx done clears when a new general-purpose transmission is requested.
// - network availability flag low while network write/read executes, else high.
// - after network instruction, fault flag high on abnormality, low otherwise.
// - on abnormality store error code and port end code words.
// - arc control flag high while arc pulse instruction executes.
// - continuation mode confirm flag shows when next arc data may be overwritten.
// - flags may change within one scan; no stability across a scan.
// - link error flag sets on a link transmission error.
// - link error flag also sets on erroneous link area settings.
// - one assurance bit per node, node 1 at bit 0, set when communicating.
// - assurance bit clears on stop, error, or link area zero mode off.
// - mode flag high for general-purpose serial, low for message protocol.
`default_nettype none
`include "clsf_regs.vh"

module clsf_status_flags (
  input  wire        clk,
  input  wire        arst_n,
  // register port
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  // second serial port events
  input  wire        gp_mode_sel,
  input  wire        port2_tx_error,
  input  wire        serial_transmit_req,
  input  wire        port2_terminator_rx,
  input  wire        port2_tx_complete,
  // network write/read instruction
  input  wire        netcmd_busy,
  input  wire        netcmd_end,
  input  wire        netcmd_abnormal,
  input  wire [15:0] netcmd_error_code,
  input  wire [15:0] netcmd_end_code,
  // arc interpolation
  input  wire        arc_busy,
  input  wire        arc_continuation,
  input  wire        arc_next_free,
  // controller link
  input  wire        link_tx_error,
  input  wire        link_area_bad,
  input  wire        link_run,
  input  wire        link_area_zero,
  input  wire [15:0] node_ok,
  // flag outputs
  output reg         irq,
  output reg         port2_mode_flag,
  output reg         port2_error_flag,
  output reg         port2_rx_done_flag,
  output reg         port2_tx_done_flag,
  output reg         port2_netcmd_available_flag,
  output reg         port2_netcmd_fault_flag,
  output reg         arc_control_flag,
  output reg         arc_overwrite_confirm_flag,
  output reg         link_tx_error_flag,
  output reg  [15:0] assure_flags
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam NIN = 17;
  wire [NIN-1:0] async_in;
  reg  [NIN-1:0] sync1_reg;
  reg  [NIN-1:0] sync2_reg;
  reg  [15:0]    node1_reg;
  reg  [15:0]    node2_reg;
  assign async_in = {gp_mode_sel, port2_tx_error, serial_transmit_req, port2_terminator_rx,
                     port2_tx_complete, netcmd_busy, netcmd_end, netcmd_abnormal, arc_busy,
                     arc_continuation, arc_next_free, link_tx_error, link_area_bad,
                     link_run, link_area_zero, 2'b00};

  // two-stage synchroniser for pin levels
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= {NIN{1'b0}};
      sync2_reg <= {NIN{1'b0}};
      node1_reg <= `CLSF_ZERO16;
      node2_reg <= `CLSF_ZERO16;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      node1_reg <= node_ok;
      node2_reg <= node1_reg;
    end
  end

  wire s_gp    = sync2_reg[16];
  wire s_txerr = sync2_reg[15];
  wire s_txreq = sync2_reg[14];
  wire s_term  = sync2_reg[13];
  wire s_txcmp = sync2_reg[12];
  wire s_nbusy = sync2_reg[11];
  wire s_nend  = sync2_reg[10];
  wire s_nabn  = sync2_reg[9];
  wire s_arc   = sync2_reg[8];
  wire s_cont  = sync2_reg[7];
  wire s_free  = sync2_reg[6];
  wire s_lerr  = sync2_reg[5];
  wire s_lbad  = sync2_reg[4];
  wire s_lrun  = sync2_reg[3];
  wire s_lz    = sync2_reg[2];

  // ************************************************************
  // edge detection of event inputs
  // ************************************************************
  reg [5:0] prev_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= `CLSF_ZERO6;
    end else begin
      prev_reg <= {s_txerr, s_txreq, s_term, s_txcmp, s_nend, s_lerr};
    end
  end
  wire e_txerr = s_txerr & ~prev_reg[5];
  wire e_txreq = s_txreq & ~prev_reg[4];
  wire e_term  = s_term  & ~prev_reg[3];
  wire e_txcmp = s_txcmp & ~prev_reg[2];
  wire e_nend  = s_nend  & ~prev_reg[1];
  wire e_lerr  = s_lerr  & ~prev_reg[0];

  // ************************************************************
  // flag registers
  // ************************************************************
  reg [15:0] err_code_reg;
  reg [15:0] end_code_reg;

  // sticky and level flags; set wins over a clear in the same cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port2_mode_flag             <= `CLSF_ZERO1;
      port2_error_flag            <= `CLSF_ZERO1;
      port2_rx_done_flag          <= `CLSF_ZERO1;
      port2_tx_done_flag          <= `CLSF_ZERO1;
      port2_netcmd_available_flag <= `CLSF_ONE1;
      port2_netcmd_fault_flag     <= `CLSF_ZERO1;
      arc_control_flag            <= `CLSF_ZERO1;
      arc_overwrite_confirm_flag  <= `CLSF_ZERO1;
      link_tx_error_flag          <= `CLSF_ZERO1;
      assure_flags                <= `CLSF_ZERO16;
      err_code_reg                <= `CLSF_ZERO16;
      end_code_reg                <= `CLSF_ZERO16;
    end else begin
      port2_mode_flag <= s_gp;
      if (e_txerr)
        port2_error_flag <= `CLSF_ONE1;
      else if (e_txreq)
        port2_error_flag <= `CLSF_ZERO1;
      if (e_term && s_gp)
        port2_rx_done_flag <= `CLSF_ONE1;
      if (e_txcmp && s_gp)
        port2_tx_done_flag <= `CLSF_ONE1;
      else if (e_txreq && s_gp)
        port2_tx_done_flag <= `CLSF_ZERO1;
      port2_netcmd_available_flag <= ~s_nbusy;
      if (e_nend) begin
        port2_netcmd_fault_flag <= s_nabn;
        if (s_nabn) begin
          err_code_reg <= netcmd_error_code;
          end_code_reg <= netcmd_end_code;
        end
      end
      arc_control_flag           <= s_arc;
      arc_overwrite_confirm_flag <= s_arc & s_cont & s_free;
      link_tx_error_flag         <= s_lerr | s_lbad;
      // each node bit follows its own good status only in link area zero mode
      assure_flags <= (s_lrun && s_lz && !s_lerr && !s_lbad) ? node2_reg
                                                             : `CLSF_ZERO16;
    end
  end
  // flags update every cycle, so they are free to change within a scan

  // ************************************************************
  // interrupt status, clear and enable
  // ************************************************************
  reg  [4:0] irq_stat_reg;
  reg  [4:0] irq_en_reg;
  wire [4:0] irq_set = {e_lerr | (s_lbad & ~prev_reg[0] & ~link_tx_error_flag),
                        e_nend, e_txcmp & s_gp, e_term & s_gp, e_txerr};
  wire [4:0] irq_clr = (wr && addr == `CLSF_OFS_IRQ_CLEAR) ? wdata[4:0] : `CLSF_ZERO5;

  // set beats clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg <= `CLSF_ZERO5;
      irq_en_reg   <= `CLSF_ZERO5;
      irq          <= `CLSF_ZERO1;
    end else begin
      irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
      if (wr && addr == `CLSF_OFS_IRQ_ENABLE)
        irq_en_reg <= wdata[4:0];
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  function [15:0] port_word;
    input m, e, rx, tx, na, nf, ac, ao;
    begin
      port_word = `CLSF_ZERO16;
      port_word[`CLSF_BIT_MODE]     = m;
      port_word[`CLSF_BIT_ERR]      = e;
      port_word[`CLSF_BIT_RXDONE]   = rx;
      port_word[`CLSF_BIT_TXDONE]   = tx;
      port_word[`CLSF_BIT_NETAVAIL] = na;
      port_word[`CLSF_BIT_NETFAULT] = nf;
      port_word[`CLSF_BIT_ARCCTL]   = ac;
      port_word[`CLSF_BIT_ARCCONF]  = ao;
    end
  endfunction

  // read data one cycle after strobe; writes to flag words ignored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `CLSF_ZERO16;
    end else if (rd) begin
      case (addr)
        `CLSF_OFS_PORT_FLAGS: rdata <= port_word(port2_mode_flag, port2_error_flag,
                                  port2_rx_done_flag, port2_tx_done_flag,
                                  port2_netcmd_available_flag, port2_netcmd_fault_flag,
                                  arc_control_flag, arc_overwrite_confirm_flag);
        `CLSF_OFS_LINK_FLAGS: rdata <= {15'h0000, link_tx_error_flag};
        `CLSF_OFS_ASSURE:     rdata <= assure_flags;
        `CLSF_OFS_ERR_CODE:   rdata <= err_code_reg;
        `CLSF_OFS_END_CODE:   rdata <= end_code_reg;
        `CLSF_OFS_IRQ_STATUS: rdata <= {11'h000, irq_stat_reg};
        `CLSF_OFS_IRQ_ENABLE: rdata <= {11'h000, irq_en_reg};
        default:              rdata <= `CLSF_ZERO16;
      endcase
    end else begin
      rdata <= `CLSF_ZERO16;
    end
  end

endmodule // clsf_status_flags
`default_nettype wire

/* verif/clsf_remote_model.sv */
// far side model: serial peer and link nodes
`default_nettype none
module clsf_remote_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        tx_req,
  input  wire logic [3:0]  dly,
  input  wire logic [15:0] up,
  output var  logic        tx_done,
  output var  logic        term,
  output var  logic [15:0] node_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       req_q;
  logic [4:0] cnt;
  // frame ends dly cycles after a request, reply terminator one cycle later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {req_q, tx_done, term, cnt, node_ok} <= '0;
    end else begin
      req_q   <= tx_req;
      node_ok <= up;
      tx_done <= (cnt == 5'h01);
      term    <= tx_done;
      if (tx_req && !req_q) cnt <= {1'b0, dly};
      else if (cnt != 5'h00) cnt <= cnt - 5'h01;
    end
  end
endmodule // clsf_remote_model
`default_nettype wire

/* verif/clsf_status_flags_checker.sv */
// port checks of the status flag bank
`default_nettype none
module clsf_status_flags_checker (
  input wire logic clk, arst_n, rd, gp_mode_sel, port2_tx_error, serial_transmit_req,
  input wire logic netcmd_busy, arc_busy, arc_continuation, arc_next_free,
  input wire logic link_tx_error, link_area_bad, link_run, link_area_zero,
  input wire logic irq, port2_mode_flag, port2_error_flag, port2_tx_done_flag,
  input wire logic port2_netcmd_fault_flag, port2_netcmd_available_flag,
  input wire logic arc_control_flag, arc_overwrite_confirm_flag, link_tx_error_flag,
  input wire logic [15:0] rdata, assure_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  err_set_a: assert property ($rose(port2_tx_error) |-> ##[1:4] port2_error_flag)
    else $error("error flag missed");
  err_clr_a: assert property ($rose(serial_transmit_req) && !port2_tx_error
    |-> ##[1:4] !port2_error_flag) else $error("error flag not cleared");
  txd_clr_a: assert property ($rose(serial_transmit_req) |-> ##[1:4] !port2_tx_done_flag)
    else $error("tx done not cleared");
  mode_flag_a: assert property (gp_mode_sel[*4] |-> port2_mode_flag)
    else $error("mode flag low");
  net_avail_a: assert property (netcmd_busy[*4] |-> !port2_netcmd_available_flag)
    else $error("available while busy");
  arc_conf_a: assert property ((arc_busy && arc_continuation && arc_next_free)[*4]
    |-> arc_overwrite_confirm_flag && arc_control_flag) else $error("arc flags");
  link_err_a: assert property ((link_tx_error || link_area_bad)[*4] |-> link_tx_error_flag)
    else $error("link error flag low");
  assure_off_a: assert property ((!link_run || !link_area_zero || link_tx_error)[*4]
    |-> assure_flags == 16'h0000) else $error("assurance bits set");
  rd_idle_a: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
  cover property ($rose(port2_netcmd_fault_flag));
  cover property ($rose(irq));
  cover property ($rose(arc_overwrite_confirm_flag));
endmodule // clsf_status_flags_checker
bind clsf_status_flags clsf_status_flags_checker chk (.*);
`default_nettype wire

/* verif/clsf_status_flags_tb.sv */
// self-checking bench of the status flag bank
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module clsf_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, wr, rd, gp, te, rq, tc, tr, nb, ne, ab, ar, co, nx, le, lb, lr, lz;
  logic irq, mf, ef, rf, tf, af, ff, cf, of, lf;
  logic [3:0] addr, dly;
  logic [15:0] wdata, rdata, ec, nc, up, nok, as;
  int bad_count, n_checks;
  clsf_remote_model peer (.clk(clk), .arst_n(arst_n), .tx_req(rq), .dly(dly), .up(up),
    .tx_done(tc), .term(tr), .node_ok(nok));
  clsf_status_flags uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .gp_mode_sel(gp), .port2_tx_error(te), .serial_transmit_req(rq),
    .port2_terminator_rx(tr), .port2_tx_complete(tc), .netcmd_busy(nb), .netcmd_end(ne),
    .netcmd_abnormal(ab), .netcmd_error_code(ec), .netcmd_end_code(nc), .arc_busy(ar),
    .arc_continuation(co), .arc_next_free(nx), .link_tx_error(le), .link_area_bad(lb),
    .link_run(lr), .link_area_zero(lz), .node_ok(nok), .irq(irq), .port2_mode_flag(mf),
    .port2_error_flag(ef), .port2_rx_done_flag(rf), .port2_tx_done_flag(tf),
    .port2_netcmd_available_flag(af), .port2_netcmd_fault_flag(ff), .arc_control_flag(cf),
    .arc_overwrite_confirm_flag(of), .link_tx_error_flag(lf), .assure_flags(as));
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(int n); repeat (n) @(posedge clk); #1; endtask
  task automatic bw(logic [3:0] a, logic [15:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic br(logic [3:0] a, logic [15:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // transmit request, flags cleared before the peer ends the frame
  task automatic send;
    @(posedge clk) begin rq <= 1'b1; dly <= 4'($urandom_range(15, 2)); end
    cyc(4); `CHK({ef, tf}, 2'b00)
    @(posedge clk) rq <= 1'b0;
    cyc(25);
  endtask
  task automatic err_ev;
    @(posedge clk) te <= 1'b1;
    cyc(2); @(posedge clk) te <= 1'b0;
    cyc(6); `CHK(ef, 1'b1)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin #200us; bad_count++; wrap_up(); end
  // main sequence
  initial begin
    {arst_n, wr, rd, gp, te, rq, nb, ne, ab, ar, co, nx, le, lb, lr, lz} = '0;
    {addr, dly, wdata, ec, nc, up} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(46));
    cyc(1); `CHK({af, ef, tf, irq, as}, 20'h80000)
    br(4'h0, 16'h0400); bw(4'h0, 16'hffff); br(4'h0, 16'h0400); br(4'hf, 16'h0000);
    send(); `CHK({rf, tf, mf}, 3'b000)
    $display("reset and message mode done");
    @(posedge clk) gp <= 1'b1;
    bw(4'h7, 16'h001f); cyc(4); `CHK(mf, 1'b1)
    for (int i = 0; i < 3; i++) begin
      err_ev(); `CHK(irq, 1'b1)
      send(); `CHK({rf, tf, ef}, 3'b110)
    end
    br(4'h5, 16'h0007); bw(4'h6, 16'h0007); cyc(3); `CHK(irq, 1'b0)
    bw(4'h7, 16'h0000); err_ev(); `CHK(irq, 1'b0)
    br(4'h5, 16'h0001); bw(4'h7, 16'h0001); cyc(3); `CHK(irq, 1'b1)
    bw(4'h6, 16'h0001); cyc(3); `CHK(irq, 1'b0)
    $display("serial and interrupt done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin nb <= 1'b1; ab <= i[0]; ec <= 16'($urandom); nc <= 16'($urandom); end
      cyc(5); `CHK(af, 1'b0)
      @(posedge clk) begin nb <= 1'b0; ne <= 1'b1; end
      cyc(5); `CHK({af, ff}, {1'b1, i[0]})
      if (i[0]) begin br(4'h3, ec); br(4'h4, nc); end
      @(posedge clk) ne <= 1'b0;
    end
    $display("network instruction done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {ar, co, nx} <= i[2:0];
      cyc(5); `CHK({cf, of}, {i[2], &i[2:0]})
    end
    $display("arc done");
    @(posedge clk) begin {lr, lz} <= 2'b11; up <= 16'($urandom); end
    cyc(6); `CHK({lf, as}, {1'b0, up})
    @(posedge clk) le <= 1'b1;
    cyc(6); `CHK({lf, as}, 17'h10000)
    @(posedge clk) begin le <= 1'b0; lb <= 1'b1; end
    cyc(6); br(4'h1, 16'h0001);
    @(posedge clk) lb <= 1'b0;
    cyc(6); `CHK({lf, as}, {1'b0, up})
    @(posedge clk) lz <= 1'b0;
    cyc(6); `CHK(as, 16'h0000)
    @(posedge clk) {lr, lz} <= 2'b01;
    cyc(6); `CHK(as, 16'h0000)
    $display("link done");
    wrap_up();
  end
endmodule // clsf_status_flags_tb
`default_nettype wire
